// ---- rtl/asc_regs.vh ----
/*
 * constants of the scan and calibration sequencer: apb map, field
 * positions, reset values, phase durations and slot encodings.
 * assumes a 100 MHz mclk; every time but ASC_CAL_GAP_MIN is kept in ms and turned into
 * cycles by the timer from ASC_MS_CYC.
 */
`ifndef ASC_REGS_VH
`define ASC_REGS_VH

// clock and time base
`define ASC_CLK_HZ       100000000
`define ASC_MS_CYC       17'd100000
`define ASC_GAIN_MS      19'd101
`define ASC_OFFS_MS      19'd73
`define ASC_CAL_GAP_MIN  5
`define ASC_CAL_GAP_MS   19'd300000

// channel update time per filter setting
`define ASC_FLT_60       3'd0
`define ASC_FLT_50       3'd1
`define ASC_FLT_10       3'd2
`define ASC_FLT_250      3'd3
`define ASC_FLT_500      3'd4
`define ASC_FLT_1K       3'd5
`define ASC_UPD_60_MS    19'd56
`define ASC_UPD_50_MS    19'd66
`define ASC_UPD_10_MS    19'd305
`define ASC_UPD_250_MS   19'd18
`define ASC_UPD_500_MS   19'd12
`define ASC_UPD_1K_MS    19'd9

// apb byte offsets
`define ASC_A_CTRL       8'h00
`define ASC_A_STAT       8'h04
`define ASC_A_ERR        8'h08
`define ASC_A_INVALID    8'h0c
`define ASC_A_OPEN       8'h10
`define ASC_A_RANGE      8'h14
`define ASC_A_CFG0       8'h20
`define ASC_A_DATA0      8'h40

// control and channel config fields
`define ASC_CTRL_CYC     0
`define ASC_CTRL_INIT    1
`define ASC_CTRL_RST     1'b1
`define ASC_CFG_EN       0
`define ASC_CFG_FLT_LO   1
`define ASC_CFG_CLS_LO   4
`define ASC_CFG_TC       8
`define ASC_CFG_RST      9'h000

// module error types and codes
`define ASC_ET_NONE      3'b000
`define ASC_ET_HW        3'b001
`define ASC_ET_CFG       3'b010
`define ASC_EX_HW        9'h001
`define ASC_EX_FLT0      9'h004

// slot kinds and the reference slot index
`define ASC_K_ACQ        2'd0
`define ASC_K_GAIN       2'd1
`define ASC_K_OFFS       2'd2
`define ASC_CJC          4'd8

`endif

// ---- rtl/asc_ms_timer.v ----
/*
 * millisecond phase timer: a load pulse starts a count of load_ms
 * milliseconds, done pulses for one cycle at its end.
 * assumes load is a single-cycle pulse from logic on mclk.
 */
`timescale 1ns/1ps

module asc_ms_timer #(
    parameter [16:0] CYC_PER_MS = 17'd100000
) (
    // clock and reset
    input  wire        mclk,
    input  wire        srst,
    // control
    input  wire        load,
    input  wire [18:0] load_ms,
    // status
    output reg         done,
    output reg         busy
);

`include "asc_regs.vh"

localparam [16:0] PRE_TOP = CYC_PER_MS - 17'd1;

reg [16:0] pre_r;
reg [18:0] left_r;

////////////////////////////////////////////////////////////////////////
always @(posedge mclk) begin
    if (srst) begin
        pre_r  <= 17'h0;
        left_r <= 19'h0;
        done   <= 1'b0;
        busy   <= 1'b0;
    end else begin
        done <= 1'b0;
        if (load) begin
            pre_r <= 17'h0;
            // never shorter than one ms
            left_r <= (load_ms == 19'h0) ? 19'h1 : load_ms;
            busy   <= 1'b1;
        end else if (busy) begin
            if (pre_r == PRE_TOP) begin
                pre_r  <= 17'h0;
                left_r <= left_r - 19'h1;
                if (left_r == 19'h1) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end
            end else begin
                pre_r <= pre_r + 17'h1;
            end
        end
    end
end

endmodule

// ---- rtl/asc_seq.v ----
/*
 * scan and calibration sequencer for eight analog channels plus the
 * cold junction reference, with channel diagnostics and apb registers.
 * assumes an analog front end on mclk that converts one slot per
 * fe_start and presents result and range flags at the slot's end.
 */
// Register access over APB and the address map were decided locally.
// What this block does
// - cyclic cal adds one gain phase (101 ms), next scan one offset phase (73 ms)
// - channel of an already calibrated class is skipped, no added scan time
// - after all classes, reference gets gain then offset in two more scans if some channel is a thermocouple
// - after a full cal cycle, plain scans for 5 minutes, then cal again
// - start-up cal of enabled channels on run entry, init, reset, whatever the cyclic cal enable
// - during start-up cal data is held and every invalid bit reads 1
// - start-up: gain and offset per channel and reference, then one acquisition each
// - scan = enabled channel times plus one reference slot at slowest tc filter
// - green indicator lit only with power on and self-tests passed
// - failed power-up self-test keeps indicator dark and reports module error
// - errors shown at once on indicator; hardware and config faults reported
// - range and open flags in the range and open registers, not in input data; hardware faults in error word
// - enabled channels checked every scan for config and range, every other scan for open circuit
// - invalid channel configuration raises an error report
// - over and under range flags of each channel kept in the range register
// - open-circuit test every other scan, per-channel flags in the open register
// - update time by filter: 10 Hz 305 ms, 60 Hz 56 ms, 1 kHz 9 ms
// - reference sampled once per scan only if some channel is a thermocouple
// - cyclic cal on by default; online config change starts cal, data held
`timescale 1ns/1ps
`include "asc_regs.vh"

module asc_seq #(
    parameter [16:0] CYC_PER_MS = `ASC_MS_CYC,
    parameter [18:0] CAL_GAP_MS = `ASC_CAL_GAP_MS
) (
    // clock and reset
    input  wire        mclk,
    input  wire        srst,
    // apb slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // device pins
    input  wire        transition_a,
    input  wire        selftest_done,
    input  wire        selftest_fail,
    input  wire        hw_fault,
    // analog front end
    input  wire [15:0] fe_data,
    input  wire        fe_over,
    input  wire        fe_under,
    input  wire        fe_open,
    output reg         fe_start,
    output reg  [3:0]  fe_chan,
    output reg  [1:0]  fe_kind,
    output reg         fe_oc_test,
    // status
    output reg         led_ok,
    output reg  [11:0] mod_err,
    output reg  [7:0]  channel_data_invalid_bits
);

localparam [2:0] ST_WAIT   = 3'd0;
localparam [2:0] ST_SU_CAL = 3'd1;
localparam [2:0] ST_SU_ACQ = 3'd2;
localparam [2:0] ST_SCAN   = 3'd3;
localparam [2:0] ST_CAL    = 3'd4;

reg  [8:0]  cfg_r [0:7];
reg  [15:0] data_r [0:7];
reg  [3:0]  s1_r, s2_r, s3_r, pin_r;
reg         run_d_r;
reg         st_pass_r;
reg         cyc_en_r;
reg  [2:0]  state_r;
reg  [3:0]  idx_r;
reg         ph_r;
reg         busy_r;
reg         su_req_r;
reg         cal_act_r;
reg  [15:0] cls_done_r;
reg         cjc_done_r;
reg         cal_ph_r;
reg  [3:0]  cal_item_r;
reg         oc_scan_r;
reg  [7:0]  hold_r, open_r, over_r, under_r;
reg         slot_ld_r, gap_ld_r;
reg  [18:0] slot_ms_r;

wire [7:0]  en, tc, bad, need_cal, cfg_hit;
wire [18:0] upd_ms [0:7];
wire        slot_done, gap_done;
wire        any_tc   = |tc;
wire        hw_err   = pin_r[2] | pin_r[3];
wire        run_ok   = st_pass_r & ~hw_err;
wire        su_go    = su_req_r & run_ok;
wire        wr_en    = psel & penable & pready & pwrite;
wire        init_wr  = wr_en & (paddr == `ASC_A_CTRL) & pwdata[`ASC_CTRL_INIT];
wire        run_rise = pin_r[0] & ~run_d_r;
wire        online   = (state_r == ST_SCAN) | (state_r == ST_CAL);
wire        cyc_end;

function [18:0] flt_ms;
    input [2:0] f;
    begin
        case (f)
            `ASC_FLT_60:  flt_ms = `ASC_UPD_60_MS;
            `ASC_FLT_50:  flt_ms = `ASC_UPD_50_MS;
            `ASC_FLT_10:  flt_ms = `ASC_UPD_10_MS;
            `ASC_FLT_250: flt_ms = `ASC_UPD_250_MS;
            `ASC_FLT_500: flt_ms = `ASC_UPD_500_MS;
            default:      flt_ms = `ASC_UPD_1K_MS;
        endcase
    end
endfunction

////////////////////////////////////////////////////////////////////////
genvar g;
generate
    for (g = 0; g < 8; g = g + 1) begin : ch
        assign en[g]     = cfg_r[g][`ASC_CFG_EN];
        assign tc[g]     = en[g] & cfg_r[g][`ASC_CFG_TC];
        assign upd_ms[g] = flt_ms(cfg_r[g][3:1]);
        assign bad[g]      = en[g] & (cfg_r[g][3:1] > `ASC_FLT_1K);
        assign need_cal[g] = en[g] & ~cls_done_r[cfg_r[g][7:4]];
        assign cfg_hit[g]  = wr_en & (paddr == (`ASC_A_CFG0 + 8'd4 * g));
    end
endgenerate

////////////////////////////////////////////////////////////////////////
// reference slot lasts as the slowest thermocouple channel
reg [18:0] cjc_ms;
reg [3:0]  pick;
reg        pick_ok;
reg [3:0]  bad_ch;
integer    i;
always @* begin
    cjc_ms  = 19'h0;
    pick    = `ASC_CJC;
    pick_ok = 1'b0;
    bad_ch  = 4'h0;
    for (i = 7; i >= 0; i = i - 1) begin
        if (tc[i] && upd_ms[i] > cjc_ms) begin
            cjc_ms = upd_ms[i];
        end
        if (need_cal[i]) begin
            pick    = i[3:0];
            pick_ok = 1'b1;
        end
        if (bad[i]) begin
            bad_ch = i[3:0];
        end
    end
    if (!pick_ok && any_tc && !cjc_done_r) begin
        pick_ok = 1'b1;
    end
end

// slot wanted in the present step, its kind and length
reg        need;
reg [18:0] tms;
reg [1:0]  kind;
reg [3:0]  ch_sel;
always @* begin
    need   = 1'b0;
    tms    = `ASC_GAIN_MS;
    kind   = `ASC_K_ACQ;
    ch_sel = idx_r;
    case (state_r)
        ST_SU_CAL: begin
            need = (idx_r == `ASC_CJC) ? any_tc : en[idx_r[2:0]];
            tms  = ph_r ? `ASC_OFFS_MS : `ASC_GAIN_MS;
            kind = ph_r ? `ASC_K_OFFS : `ASC_K_GAIN;
        end
        ST_SU_ACQ, ST_SCAN: begin
            // channel slots plus one reference slot
            need = (idx_r == `ASC_CJC) ? any_tc : en[idx_r[2:0]];
            tms  = (idx_r == `ASC_CJC) ? cjc_ms : upd_ms[idx_r[2:0]];
        end
        ST_CAL: begin
            need   = 1'b1;
            ch_sel = cal_item_r;
            tms    = cal_ph_r ? `ASC_OFFS_MS : `ASC_GAIN_MS;
            kind   = cal_ph_r ? `ASC_K_OFFS : `ASC_K_GAIN;
        end
        default: need = 1'b0;
    endcase
end

wire step     = busy_r ? slot_done : ~need;
wire acq_done = slot_done & (fe_kind == `ASC_K_ACQ) & (fe_chan != `ASC_CJC)
              & ((state_r == ST_SU_ACQ) | (state_r == ST_SCAN));
wire [2:0] ach = fe_chan[2:0];
assign cyc_end = (state_r == ST_SCAN) & step & (idx_r == `ASC_CJC) & cal_act_r & ~pick_ok;

////////////////////////////////////////////////////////////////////////
// pins: three flops, a level counts once stages two and three agree
always @(posedge mclk) begin
    if (srst) begin
        s1_r      <= 4'h0;
        s2_r      <= 4'h0;
        s3_r      <= 4'h0;
        pin_r     <= 4'h0;
        run_d_r   <= 1'b0;
        st_pass_r <= 1'b0;
    end else begin
        s1_r    <= {hw_fault, selftest_fail, selftest_done, transition_a};
        s2_r    <= s1_r;
        s3_r    <= s2_r;
        pin_r   <= (pin_r & (s2_r ^ s3_r)) | (s3_r & ~(s2_r ^ s3_r));
        run_d_r <= pin_r[0];
        // pass latched only after clean self-test
        if (pin_r[1] && !pin_r[2]) begin
            st_pass_r <= 1'b1;
        end
    end
end

// indicator and error word follow faults at once
always @(posedge mclk) begin
    if (srst) begin
        led_ok  <= 1'b0;
        mod_err <= 12'h0;
    end else begin
        led_ok <= st_pass_r & ~hw_err & ~(|bad);
        if (hw_err) begin
            mod_err <= {`ASC_ET_HW, `ASC_EX_HW};
        end else if (|bad) begin
            mod_err <= {`ASC_ET_CFG, `ASC_EX_FLT0 + {5'h0, bad_ch}};
        end else begin
            mod_err <= {`ASC_ET_NONE, 9'h0};
        end
    end
end

////////////////////////////////////////////////////////////////////////
// sequencer
always @(posedge mclk) begin
    if (srst) begin
        state_r    <= ST_WAIT;
        idx_r      <= 4'h0;
        ph_r       <= 1'b0;
        busy_r     <= 1'b0;
        su_req_r   <= 1'b1;
        cal_act_r  <= 1'b0;
        cls_done_r <= 16'h0;
        cjc_done_r <= 1'b0;
        cal_ph_r   <= 1'b0;
        cal_item_r <= 4'h0;
        oc_scan_r  <= 1'b0;
        slot_ld_r  <= 1'b0;
        gap_ld_r   <= 1'b0;
        slot_ms_r  <= 19'h0;
        fe_start   <= 1'b0;
        fe_chan    <= 4'h0;
        fe_kind    <= `ASC_K_ACQ;
        fe_oc_test <= 1'b0;
        channel_data_invalid_bits <= 8'hff;
    end else begin
        fe_start  <= 1'b0;
        slot_ld_r <= 1'b0;
        gap_ld_r  <= 1'b0;
        // start-up request, a new request wins over its take
        su_req_r <= (su_req_r & ~su_go) | run_rise | init_wr;
        if (!run_ok) begin
            state_r <= ST_WAIT;
            busy_r  <= 1'b0;
        end else if (su_go) begin
            state_r <= ST_SU_CAL;
            idx_r   <= 4'h0;
            ph_r    <= 1'b0;
            busy_r  <= 1'b0;
            channel_data_invalid_bits <= 8'hff;
        end else if (state_r != ST_WAIT) begin
            if (!busy_r && need) begin
                busy_r     <= 1'b1;
                slot_ld_r  <= 1'b1;
                slot_ms_r  <= tms;
                fe_start   <= 1'b1;
                fe_chan    <= ch_sel;
                fe_kind    <= kind;
                fe_oc_test <= (state_r == ST_SCAN) & oc_scan_r & (kind == `ASC_K_ACQ);
                // flip at launch, so a restart mid-slot begins with gain
                if (state_r == ST_CAL) begin
                    cal_ph_r <= ~cal_ph_r;
                end
            end else if (step) begin
                busy_r <= 1'b0;
            end
            // first valid acquisition clears the bit
            if (acq_done && state_r == ST_SU_ACQ) begin
                channel_data_invalid_bits[ach] <= 1'b0;
            end
            if (step) begin
                case (state_r)
                    ST_SU_CAL: begin
                        // gain and offset for every needed item, others skipped
                        if (ph_r || !need) begin
                            ph_r <= 1'b0;
                            idx_r <= (idx_r == `ASC_CJC) ? `ASC_CJC : idx_r + 4'h1;
                            if (idx_r == `ASC_CJC) begin
                                state_r <= ST_SU_ACQ;
                            end
                        end else begin
                            ph_r <= 1'b1;
                        end
                    end
                    ST_SU_ACQ: begin
                        if (idx_r == `ASC_CJC) begin
                            idx_r <= 4'h0;
                        end else if (idx_r == 4'h7) begin
                            idx_r     <= 4'h0;
                            state_r   <= ST_SCAN;
                            cal_act_r <= 1'b0;
                            gap_ld_r  <= 1'b1;
                        end else begin
                            idx_r <= idx_r + 4'h1;
                        end
                    end
                    ST_SCAN: begin
                        if (idx_r == `ASC_CJC) begin
                            idx_r <= 4'h0;
                            oc_scan_r <= ~oc_scan_r;
                            if (cal_act_r && pick_ok) begin
                                state_r    <= ST_CAL;
                                cal_item_r <= pick;
                            end else if (cal_act_r) begin
                                cal_act_r <= 1'b0;
                                gap_ld_r  <= 1'b1;
                            end
                        end else begin
                            idx_r <= idx_r + 4'h1;
                        end
                    end
                    ST_CAL: begin
                        state_r <= ST_SCAN;
                        // class marked after its offset phase
                        if (fe_kind == `ASC_K_OFFS && cal_item_r == `ASC_CJC) begin
                            cjc_done_r <= 1'b1;
                        end else if (fe_kind == `ASC_K_OFFS) begin
                            cls_done_r[cfg_r[cal_item_r[2:0]][7:4]] <= 1'b1;
                        end
                    end
                    default: state_r <= ST_WAIT;
                endcase
            end
            // gap over: new cycle, or wait another gap
            if (gap_done && online) begin
                if (cyc_en_r) begin
                    cal_act_r <= 1'b1;
                end else begin
                    gap_ld_r <= 1'b1;
                end
            end
            // online change starts a cycle afresh
            if ((|cfg_hit) && online) begin
                cal_act_r <= 1'b1;
            end
            if (((|cfg_hit) || (gap_done && cyc_en_r)) && online) begin
                cls_done_r <= 16'h0;
                cjc_done_r <= 1'b0;
                cal_ph_r   <= 1'b0;
            end
        end
    end
end

////////////////////////////////////////////////////////////////////////
// held channels skip updates until cycle ends or start-up starts; set wins
always @(posedge mclk) begin
    if (srst) begin
        hold_r <= 8'h0;
    end else begin
        hold_r <= (hold_r & ~{8{cyc_end | su_go}}) | (cfg_hit & {8{online}});
    end
end

// per-scan range and open flags, bit n is channel n
always @(posedge mclk) begin
    if (srst) begin
        open_r  <= 8'h0;
        over_r  <= 8'h0;
        under_r <= 8'h0;
    end else if (acq_done && !hold_r[ach]) begin
        over_r[ach]  <= fe_over;
        under_r[ach] <= fe_under;
        if (fe_oc_test) begin
            open_r[ach] <= fe_open;
        end
    end
end

// data written only by real acquisitions
always @(posedge mclk) begin
    if (acq_done && !hold_r[ach]) begin
        data_r[ach] <= fe_data;
    end
end

////////////////////////////////////////////////////////////////////////
// apb writes
integer    k;
always @(posedge mclk) begin
    if (srst) begin
        cyc_en_r <= `ASC_CTRL_RST;
        for (k = 0; k < 8; k = k + 1) begin
            cfg_r[k] <= `ASC_CFG_RST;
        end
    end else if (wr_en) begin
        if (paddr == `ASC_A_CTRL) begin
            cyc_en_r <= pwdata[`ASC_CTRL_CYC];
        end
        for (k = 0; k < 8; k = k + 1) begin
            if (cfg_hit[k]) begin
                cfg_r[k] <= pwdata[8:0];
            end
        end
    end
end

// read decode; one wait state, pready high in the second access cycle
reg [31:0] rd_nxt;
reg        err_nxt;
always @* begin
    rd_nxt  = 32'h0;
    err_nxt = 1'b0;
    if (paddr == `ASC_A_CTRL) begin
        rd_nxt = {31'h0, cyc_en_r};
    end else if (paddr == `ASC_A_STAT) begin
        rd_nxt = {21'h0, idx_r, state_r, cal_act_r, su_req_r, led_ok};
    end else if (paddr == `ASC_A_ERR) begin
        rd_nxt = {20'h0, mod_err};
    end else if (paddr == `ASC_A_INVALID) begin
        rd_nxt = {24'h0, channel_data_invalid_bits};
    end else if (paddr == `ASC_A_OPEN) begin
        rd_nxt = {24'h0, open_r};
    end else if (paddr == `ASC_A_RANGE) begin
        rd_nxt = {16'h0, over_r, under_r};
    end else if (paddr[7:5] == 3'b001 && paddr[1:0] == 2'b00) begin
        rd_nxt = {23'h0, cfg_r[paddr[4:2]]};
    end else if (paddr[7:5] == 3'b010 && paddr[1:0] == 2'b00) begin
        rd_nxt = {16'h0, data_r[paddr[4:2]]};
    end else begin
        err_nxt = 1'b1;
    end
end

always @(posedge mclk) begin
    if (srst) begin
        pready  <= 1'b0;
        pslverr <= 1'b0;
        prdata  <= 32'h0;
    end else begin
        pready  <= psel & penable & ~pready;
        pslverr <= psel & penable & ~pready & err_nxt;
        if (psel && penable && !pready && !pwrite) begin
            prdata <= rd_nxt;
        end
    end
end

////////////////////////////////////////////////////////////////////////
asc_ms_timer #(.CYC_PER_MS(CYC_PER_MS)) u_slot (
    .mclk    (mclk),
    .srst    (srst),
    .load    (slot_ld_r),
    .load_ms (slot_ms_r),
    .done    (slot_done),
    .busy    ()
);

asc_ms_timer #(.CYC_PER_MS(CYC_PER_MS)) u_gap (
    .mclk    (mclk),
    .srst    (srst),
    .load    (gap_ld_r),
    .load_ms (CAL_GAP_MS),
    .done    (gap_done),
    .busy    ()
);

endmodule

// ---- tb/asc_seq_checker.sv ----
/* checker: apb answer, slot lengths, pairing and indicator of asc_seq.
   assumes only the ports of asc_seq, bound in from the bench top. */
`timescale 1ns/1ps
`include "asc_regs.vh"
module asc_seq_checker #(
    parameter [16:0] CYC_PER_MS = 17'd10
) (
    // watched ports
    input wire        mclk,
    input wire        srst,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire        pready,
    input wire        pslverr,
    input wire        transition_a,
    input wire        selftest_fail,
    input wire        hw_fault,
    input wire        fe_start,
    input wire [3:0]  fe_chan,
    input wire [1:0]  fe_kind,
    input wire        fe_oc_test,
    input wire        led_ok,
    input wire [11:0] mod_err
);
    localparam int GC = 101 * CYC_PER_MS;
    localparam int OC = 73 * CYC_PER_MS;
    reg [1:0] kind_r;
    reg [3:0] gch_r;
    reg       tr_r;
    int       cnt_r;
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);
    // faults, writes and mode edges may cut a slot short, so forget it
    always @(posedge mclk) begin
        tr_r <= transition_a;
        if (srst || hw_fault || (psel && pwrite) || transition_a != tr_r) begin
            kind_r <= `ASC_K_ACQ;
            cnt_r <= 0;
        end else if (fe_start) begin
            kind_r <= fe_kind;
            cnt_r <= 1;
            if (fe_kind == `ASC_K_GAIN) gch_r <= fe_chan;
        end else begin
            cnt_r <= cnt_r + 1;
        end
    end
    sequence s_gain_end; fe_start && kind_r == `ASC_K_GAIN; endsequence
    sequence s_offs_end; fe_start && kind_r == `ASC_K_OFFS; endsequence
    a_apb_one_wait: assert property (psel && penable && !pready |=> pready) else $error("late");
    a_ready_pulse: assert property (pready |=> !pready) else $error("ready held");
    a_err_ready: assert property (pslverr |-> pready) else $error("stray error");
    a_slot_gap: assert property (fe_start |=> (!fe_start)[*8]) else $error("slot short");
    a_oc_acq: assert property (fe_oc_test |-> fe_kind == `ASC_K_ACQ) else $error("oc");
    // up to seven disabled indices are stepped over before the next slot
    a_gain_len: assert property (s_gain_end |-> cnt_r >= GC && cnt_r <= GC + 10)
        else $error("gain length");
    a_offs_len: assert property (s_offs_end |-> cnt_r >= OC && cnt_r <= OC + 10)
        else $error("offset length");
    a_offs_pair: assert property (fe_start && fe_kind == `ASC_K_OFFS |-> fe_chan == gch_r)
        else $error("offset unpaired");
    a_fail_dark: assert property (selftest_fail[*8] |-> !led_ok) else $error("lit");
    a_hw_dark: assert property (hw_fault[*8] |-> !led_ok && mod_err != 12'h000)
        else $error("fault hidden");
endmodule

// ---- tb/asc_fe_model.sv ----
/* front end stand-in: result and flags for the channel of the slot.
   assumes fe_chan stands for the whole slot. */
`timescale 1ns/1ps
module asc_fe_model (
    // slot and stimulus
    input wire [3:0]  fe_chan,
    input wire        fe_oc_test,
    input wire [15:0] base,
    input wire [7:0]  over_m,
    input wire [7:0]  under_m,
    input wire [7:0]  open_m,
    // result
    output wire [15:0] fe_data,
    output wire        fe_over,
    output wire        fe_under,
    output wire        fe_open
);
    wire [7:0] sel = (fe_chan < 4'd8) ? (8'h01 << fe_chan) : 8'h00;
    assign fe_data = base ^ {12'h000, fe_chan};
    assign fe_over = |(over_m & sel);
    assign fe_under = |(under_m & sel);
    // open seen only while a test runs
    assign fe_open = fe_oc_test && |(open_m & sel);
endmodule

// ---- tb/asc_seq_test.sv ----
/* bench for asc_seq: apb master tasks, front end model, queue model.
   assumes 10 cycles per ms and a 3 ms calibration gap. */
`timescale 1ns/1ps
`include "asc_regs.vh"
module asc_seq_test;
    reg mclk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
    reg tr = 1'b0, st_done = 1'b0, st_fail = 1'b0, hw = 1'b0;
    reg [7:0] paddr = 8'h00, ov = 8'h00, un = 8'h00, op = 8'h00;
    reg [31:0] pwdata = 32'h0, q;
    reg [15:0] base = 16'h0;
    wire [31:0] prdata;
    wire [15:0] fd;
    wire [11:0] merr;
    wire [7:0] inv;
    wire [3:0] fc;
    wire pready, pslverr, fo, fu, fop, fot, led;
    int fail_count = 0, total_checks = 0, i, exp_q[$];
    always #5 mclk = ~mclk;
    asc_seq #(.CYC_PER_MS(17'd10), .CAL_GAP_MS(19'd3)) DUT (.mclk(mclk), .srst(srst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .transition_a(tr),
        .selftest_done(st_done), .selftest_fail(st_fail), .hw_fault(hw), .fe_data(fd),
        .fe_over(fo), .fe_under(fu), .fe_open(fop), .fe_start(), .fe_chan(fc), .fe_kind(),
        .fe_oc_test(fot), .led_ok(led), .mod_err(merr), .channel_data_invalid_bits(inv));
    asc_fe_model u_fe (.fe_chan(fc), .fe_oc_test(fot), .base(base), .over_m(ov),
        .under_m(un), .open_m(op), .fe_data(fd), .fe_over(fo), .fe_under(fu), .fe_open(fop));
    task chk(input [31:0] s, input [31:0] e, input string nm);
        total_checks++;
        if (s !== e) begin
            fail_count++;
            $display("unexpected %s exp %h seen %h", nm, e, s);
        end
    endtask
    task apb(input w, input [7:0] a, input [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask
    // status words settle slowly, so poll with a bound
    task poll(input [7:0] a, input [31:0] e, input string nm, input int tries);
        apb(1'b0, a, 32'h0);
        while (q !== e && tries > 0) begin
            repeat (50) @(posedge mclk);
            apb(1'b0, a, 32'h0);
            tries--;
        end
        chk(q, e, nm);
    endtask
    task print_verdict;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        #950000;
        fail_count++;
        print_verdict;
    end
    initial begin
        i = $urandom(32'h8e26955d);
        st_done <= 1'b1;
        st_fail <= 1'b1;
        repeat (3) @(posedge mclk);
        srst <= 1'b0;
        repeat (12) @(posedge mclk);
        chk({31'h0, led}, 32'h0, "led");
        chk({20'h0, merr}, 32'h201, "error");
        st_fail <= 1'b0;
        srst <= 1'b1;
        repeat (3) @(posedge mclk);
        srst <= 1'b0;
        @(posedge mclk);
        poll(`ASC_A_CTRL, 32'h1, "ctrl", 0);
        poll(`ASC_A_INVALID, 32'hff, "invalid", 0);
        apb(1'b0, 8'h18, 32'h0);
        chk({31'h0, err}, 32'h1, "slverr");
        base <= 16'($urandom);
        apb(1'b1, `ASC_A_CFG0, 32'h111);
        apb(1'b1, `ASC_A_CFG0 + 8'h04, 32'h113);
        apb(1'b1, `ASC_A_CFG0 + 8'h08, 32'h021);
        apb(1'b1, `ASC_A_CTRL, 32'h3);
        poll(`ASC_A_INVALID, 32'hff, "invalid", 0);
        poll(`ASC_A_INVALID, 32'hf8, "invalid", 400);
        chk({24'h0, inv}, 32'hf8, "invalid pins");
        chk({31'h0, led}, 32'h1, "led");
        for (i = 0; i < 3; i++) exp_q.push_back(base ^ i[15:0]);
        for (i = 0; i < 3; i++) poll(`ASC_A_DATA0 + 8'(4 * i), exp_q.pop_front(), "data", 0);
        un <= 8'h01;
        ov <= 8'h02;
        op <= 8'h04;
        poll(`ASC_A_OPEN, 32'h4, "open", 400);
        poll(`ASC_A_RANGE, 32'h201, "range", 400);
        apb(1'b1, `ASC_A_CFG0 + 8'h0c, 32'h00d);
        poll(`ASC_A_ERR, 32'h407, "cfg error", 100);
        apb(1'b1, `ASC_A_CFG0 + 8'h0c, 32'h0);
        hw <= 1'b1;
        repeat (10) @(posedge mclk);
        chk({31'h0, led}, 32'h0, "led");
        chk({20'h0, merr}, 32'h201, "hw error");
        hw <= 1'b0;
        tr <= 1'b1;
        poll(`ASC_A_INVALID, 32'hff, "invalid", 100);
        poll(`ASC_A_INVALID, 32'hf8, "invalid", 400);
        print_verdict;
    end
endmodule
bind asc_seq asc_seq_checker #(.CYC_PER_MS(CYC_PER_MS)) u_chk (.mclk(mclk), .srst(srst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready), .pslverr(pslverr),
    .transition_a(transition_a), .selftest_fail(selftest_fail), .hw_fault(hw_fault),
    .fe_start(fe_start), .fe_chan(fe_chan), .fe_kind(fe_kind), .fe_oc_test(fe_oc_test),
    .led_ok(led_ok), .mod_err(mod_err));
